// [alac_pkg.sv]
// Constants shared by the light-sensor converter control logic
package alac_pkg;
  // Register indices
  localparam logic [2:0] REG_SETUP   = 3'h0;
  localparam logic [2:0] REG_GAIN    = 3'h1;
  localparam logic [2:0] REG_UPPER   = 3'h2;
  localparam logic [2:0] REG_LOWER   = 3'h3;
  localparam logic [2:0] REG_RES_LO  = 3'h4;
  localparam logic [2:0] REG_RES_HI  = 3'h5;
  localparam logic [2:0] REG_CNT_LO  = 3'h6;
  localparam logic [2:0] REG_CNT_HI  = 3'h7;
  // Pointer byte strobe bits and index field width
  localparam int PTR_RESTART_BIT = 7;
  localparam int PTR_CLEAR_BIT   = 6;
  localparam int PTR_IDX_W       = 3;
  // Setup register fields
  localparam int SETUP_EN_BIT    = 7;
  localparam int SETUP_PD_BIT    = 6;
  localparam int SETUP_TMODE_BIT = 5;
  localparam int SETUP_DSEL_LSB  = 2;
  localparam int SETUP_WIDTH_LSB = 0;
  // Gain register fields
  localparam int GAIN_FLAG_BIT   = 5;
  localparam int GAIN_RANGE_LSB  = 2;
  localparam int GAIN_PERS_LSB   = 0;
  // Reset values and the fixed low byte of the limit compares
  localparam logic [7:0] UPPER_RST = 8'hff;
  localparam logic [7:0] LOWER_RST = 8'h00;
  localparam logic [7:0] LIMIT_LSB = 8'h00;
  // Diode select codes
  localparam logic [1:0] DSEL_FIRST = 2'h0;
  localparam logic [1:0] DSEL_SECOND = 2'h1;
  localparam logic [1:0] DSEL_DIFF  = 2'h2;
  localparam logic [1:0] DSEL_NOP   = 2'h3;
  // Persistence counts
  localparam logic [4:0] PERS_M0 = 5'h01;
  localparam logic [4:0] PERS_M1 = 5'h04;
  localparam logic [4:0] PERS_M2 = 5'h08;
  localparam logic [4:0] PERS_M3 = 5'h10;
  // Target address
  localparam logic [6:0] DEV_ADDR = 7'h44;
  // Range constants per gain code (informational, used by lux software)
  localparam int RANGE_K1 = 973;
  localparam int RANGE_K2 = 3892;
  localparam int RANGE_K3 = 15568;
  localparam int RANGE_K4 = 62272;
  // Oscillator timing
  localparam int CLK_KHZ      = 100000;
  localparam int OSC_FAST_KHZ = 655;
  localparam int OSC_FAST_DIV = CLK_KHZ / OSC_FAST_KHZ;
  localparam logic [8:0] DIV_FAST_LIM = 9'(OSC_FAST_DIV - 1);
  localparam logic [8:0] DIV_SLOW_LIM = 9'(2 * OSC_FAST_DIV - 1);
endpackage

// [alac_ctrl.sv]
// Light-sensor converter control: two-wire target, registers, integration and alert
`timescale 1ns/1ps
module alac_ctrl #(
  parameter int unsigned CYC_W0 = 65536,
  parameter int unsigned CYC_W1 = 4096,
  parameter int unsigned CYC_W2 = 256,
  parameter int unsigned CYC_W3 = 16
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic srst_in,
  // Two-wire bus pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe_out,
  // Front-end bitstreams
  input  wire logic diode1_in,
  input  wire logic diode2_in,
  // Alert pin
  output logic      int_n_out
);
  initial begin
    if (CYC_W0 < 1 || CYC_W0 > 65536 || CYC_W1 < 1 || CYC_W1 > 65536 ||
        CYC_W2 < 1 || CYC_W2 > 65536 || CYC_W3 < 1 || CYC_W3 > 65536) begin
      $error("alac_ctrl: cycle counts must lie in 1..65536");
    end
  end

  typedef enum logic [2:0] {I_IDLE, I_ADDR, I_PTR, I_WDATA, I_ACK, I_RDATA, I_RACK}
    alac_i2c_type;

  function automatic logic [16:0] width_cycles(input logic [1:0] code);
    case (code)
      2'h0:    width_cycles = 17'(CYC_W0);
      2'h1:    width_cycles = 17'(CYC_W1);
      2'h2:    width_cycles = 17'(CYC_W2);
      default: width_cycles = 17'(CYC_W3);
    endcase
  endfunction

  function automatic logic [15:0] sat_inc(input logic [15:0] a, input logic b);
    sat_inc = (a == 16'hffff) ? a : a + {15'h0000, b};
  endfunction

  // Input synchronisers
  logic [1:0] scl_sy_q, sda_sy_q, d1_sy_q, d2_sy_q;
  logic       scl_p_q, sda_p_q;
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      scl_sy_q <= 2'h3;
      sda_sy_q <= 2'h3;
      d1_sy_q  <= 2'h0;
      d2_sy_q  <= 2'h0;
      scl_p_q  <= 1'b1;
      sda_p_q  <= 1'b1;
    end else begin
      scl_sy_q <= {scl_sy_q[0], scl_in};
      sda_sy_q <= {sda_sy_q[0], sda_in};
      d1_sy_q  <= {d1_sy_q[0], diode1_in};
      d2_sy_q  <= {d2_sy_q[0], diode2_in};
      scl_p_q  <= scl_sy_q[1];
      sda_p_q  <= sda_sy_q[1];
    end
  end
  logic scl_s, sda_s, scl_rise, scl_fall, bus_start, bus_stop;
  assign scl_s     = scl_sy_q[1];
  assign sda_s     = sda_sy_q[1];
  assign scl_rise  = scl_s & ~scl_p_q;
  assign scl_fall  = ~scl_s & scl_p_q;
  assign bus_start = scl_s & scl_p_q & sda_p_q & ~sda_s;
  assign bus_stop  = scl_s & scl_p_q & ~sda_p_q & sda_s;

  // Register state
  logic       en_q, pd_q, tmode_q;
  logic [1:0] dsel_q, width_q, gain_q, pers_q;
  logic [7:0] upper_q, lower_q;
  logic [15:0] result_q, tcap_q;
  logic       flag_q, int_n_q;

  // Target state
  alac_i2c_type ist_q, after_q;
  logic [7:0] shift_q, ptr_q, wr_data_q;
  logic [2:0] bcnt_q, wr_idx_q;
  logic       got_q, oe_q, ackok_q, wr_q, restart_q, clear_q;
  logic [7:0] rd_byte;

  always_comb begin
    rd_byte = 8'h00;
    if (ptr_q[5:alac_pkg::PTR_IDX_W] == 3'h0) begin
      case (ptr_q[alac_pkg::PTR_IDX_W-1:0])
        alac_pkg::REG_SETUP:  rd_byte = {en_q, pd_q, tmode_q, 1'b0, dsel_q, width_q};
        alac_pkg::REG_GAIN:   rd_byte = {2'h0, flag_q, 1'b0, gain_q, pers_q};
        alac_pkg::REG_UPPER:  rd_byte = upper_q;
        alac_pkg::REG_LOWER:  rd_byte = lower_q;
        alac_pkg::REG_RES_LO: rd_byte = result_q[7:0];
        alac_pkg::REG_RES_HI: rd_byte = result_q[15:8];
        alac_pkg::REG_CNT_LO: rd_byte = tcap_q[7:0];
        alac_pkg::REG_CNT_HI: rd_byte = tcap_q[15:8];
        default:    rd_byte = 8'h00;
      endcase
    end
  end

  // Two-wire target; SDA changes while SCL is low, except the release at a start or stop
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      ist_q     <= I_IDLE;
      after_q   <= I_IDLE;
      shift_q   <= 8'h00;
      ptr_q     <= 8'h00;
      bcnt_q    <= 3'h0;
      got_q     <= 1'b0;
      oe_q      <= 1'b0;
      ackok_q   <= 1'b0;
      wr_q      <= 1'b0;
      wr_idx_q  <= 3'h0;
      wr_data_q <= 8'h00;
      restart_q <= 1'b0;
      clear_q   <= 1'b0;
    end else begin
      wr_q      <= 1'b0;
      restart_q <= 1'b0;
      clear_q   <= 1'b0;
      if (bus_start) begin
        ist_q  <= I_ADDR;
        bcnt_q <= 3'h0;
        got_q  <= 1'b0;
        oe_q   <= 1'b0;
      end else if (bus_stop) begin
        ist_q <= I_IDLE;
        oe_q  <= 1'b0;
      end else begin
        case (ist_q)
          I_ADDR, I_PTR, I_WDATA: begin
            if (scl_rise) begin
              shift_q <= {shift_q[6:0], sda_s};
              bcnt_q  <= bcnt_q + 3'h1;
              got_q   <= (bcnt_q == 3'h7);
            end else if (scl_fall && got_q) begin
              got_q <= 1'b0;
              oe_q  <= 1'b1;
              ist_q <= I_ACK;
              if (ist_q == I_ADDR) begin
                if (shift_q[7:1] == alac_pkg::DEV_ADDR) begin
                  after_q <= shift_q[0] ? I_RDATA : I_PTR;
                end else begin
                  oe_q  <= 1'b0;
                  ist_q <= I_IDLE;
                end
              end else if (ist_q == I_PTR) begin
                ptr_q     <= shift_q;
                restart_q <= shift_q[alac_pkg::PTR_RESTART_BIT];
                clear_q   <= shift_q[alac_pkg::PTR_CLEAR_BIT];
                after_q   <= I_WDATA;
              end else begin
                wr_q      <= (ptr_q[5:alac_pkg::PTR_IDX_W] == 3'h0);
                wr_idx_q  <= ptr_q[alac_pkg::PTR_IDX_W-1:0];
                wr_data_q <= shift_q;
                ptr_q     <= ptr_q + 8'h01;
                after_q   <= I_WDATA;
              end
            end
          end
          I_ACK: begin
            if (scl_fall) begin
              bcnt_q <= 3'h0;
              ist_q  <= after_q;
              if (after_q == I_RDATA) begin
                shift_q <= rd_byte;
                oe_q    <= ~rd_byte[7];
                ptr_q   <= ptr_q + 8'h01;
              end else begin
                oe_q <= 1'b0;
              end
            end
          end
          I_RDATA: begin
            if (scl_fall) begin
              if (bcnt_q == 3'h7) begin
                oe_q  <= 1'b0;
                ist_q <= I_RACK;
              end else begin
                oe_q    <= ~shift_q[6];
                shift_q <= {shift_q[6:0], 1'b0};
                bcnt_q  <= bcnt_q + 3'h1;
              end
            end
          end
          I_RACK: begin
            if (scl_rise) begin
              ackok_q <= ~sda_s;
            end else if (scl_fall) begin
              bcnt_q <= 3'h0;
              if (ackok_q) begin
                shift_q <= rd_byte;
                oe_q    <= ~rd_byte[7];
                ptr_q   <= ptr_q + 8'h01;
                ist_q   <= I_RDATA;
              end else begin
                ist_q <= I_IDLE;
              end
            end
          end
          default: ist_q <= I_IDLE;
        endcase
      end
    end
  end

  // Host-written configuration
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      en_q    <= 1'b0;
      pd_q    <= 1'b0;
      tmode_q <= 1'b0;
      dsel_q  <= alac_pkg::DSEL_FIRST;
      width_q <= 2'h0;
      gain_q  <= 2'h0;
      pers_q  <= 2'h0;
      upper_q <= alac_pkg::UPPER_RST;
      lower_q <= alac_pkg::LOWER_RST;
    end else if (wr_q) begin
      case (wr_idx_q)
        alac_pkg::REG_SETUP: begin
          en_q    <= wr_data_q[alac_pkg::SETUP_EN_BIT];
          pd_q    <= wr_data_q[alac_pkg::SETUP_PD_BIT];
          tmode_q <= wr_data_q[alac_pkg::SETUP_TMODE_BIT];
          dsel_q  <= wr_data_q[alac_pkg::SETUP_DSEL_LSB+:2];
          width_q <= wr_data_q[alac_pkg::SETUP_WIDTH_LSB+:2];
        end
        alac_pkg::REG_GAIN: begin
          gain_q <= wr_data_q[alac_pkg::GAIN_RANGE_LSB+:2];
          pers_q <= wr_data_q[alac_pkg::GAIN_PERS_LSB+:2];
        end
        alac_pkg::REG_UPPER: upper_q <= wr_data_q;
        alac_pkg::REG_LOWER: lower_q <= wr_data_q;
        default: ;
      endcase
    end
  end

  // Conversion core
  logic        active, tick, phase_end, done, out_win, alert_set;
  logic [8:0]  div_q;
  logic [16:0] cyc_q;
  logic        phase_q;
  logic [15:0] acc1_q, acc2_q, timer_q, acc1_nx, acc2_nx, res_nx;
  logic [16:0] diff;
  logic [4:0]  pcnt_q, pers_m;

  // Held in reset while disabled or powered down; no-op code integrates nothing
  assign active = en_q & ~pd_q & (dsel_q != alac_pkg::DSEL_NOP);
  // Low ranges use the slow divider so they tick at half rate
  assign tick = (div_q == (gain_q[1] ? alac_pkg::DIV_FAST_LIM :
                           alac_pkg::DIV_SLOW_LIM));
  assign phase_end = tmode_q ? restart_q :
                     (tick && (cyc_q == width_cycles(width_q) - 17'h00001));
  assign done = active & phase_end & ((dsel_q != alac_pkg::DSEL_DIFF) | phase_q);
  assign acc1_nx = sat_inc(acc1_q, tick & d1_sy_q[1] &
                   ((dsel_q == alac_pkg::DSEL_FIRST) |
                    ((dsel_q == alac_pkg::DSEL_DIFF) & ~phase_q)));
  assign acc2_nx = sat_inc(acc2_q, tick & d2_sy_q[1] &
                   ((dsel_q == alac_pkg::DSEL_SECOND) |
                    ((dsel_q == alac_pkg::DSEL_DIFF) & phase_q)));
  assign diff = {1'b0, acc1_nx} - {1'b0, acc2_nx};
  always_comb begin
    case (dsel_q)
      alac_pkg::DSEL_SECOND: res_nx = acc2_nx;
      alac_pkg::DSEL_DIFF:   res_nx = diff[16:1];
      default:               res_nx = acc1_nx;
    endcase
  end
  always_comb begin
    case (pers_q)
      2'h0:    pers_m = alac_pkg::PERS_M0;
      2'h1:    pers_m = alac_pkg::PERS_M1;
      2'h2:    pers_m = alac_pkg::PERS_M2;
      default: pers_m = alac_pkg::PERS_M3;
    endcase
  end
  assign out_win = (res_nx > {upper_q, alac_pkg::LIMIT_LSB}) |
                   (res_nx < {lower_q, alac_pkg::LIMIT_LSB});
  assign alert_set = done & out_win & ((pcnt_q + 5'h01) >= pers_m);

  always_ff @(posedge clk_in) begin
    if (srst_in || !active) begin
      div_q   <= 9'h000;
      cyc_q   <= 17'h00000;
      phase_q <= 1'b0;
      acc1_q  <= 16'h0000;
      acc2_q  <= 16'h0000;
      timer_q <= 16'h0000;
      pcnt_q  <= 5'h00;
    end else begin
      div_q   <= tick ? 9'h000 : div_q + 9'h001;
      timer_q <= timer_q + {15'h0000, tick};
      if (done) begin
        cyc_q   <= 17'h00000;
        phase_q <= 1'b0;
        acc1_q  <= 16'h0000;
        acc2_q  <= 16'h0000;
        timer_q <= 16'h0000;
        if (!out_win) begin
          pcnt_q <= 5'h00;
        end else if (pcnt_q < pers_m) begin
          pcnt_q <= pcnt_q + 5'h01;
        end
      end else if (phase_end) begin
        cyc_q   <= 17'h00000;
        phase_q <= 1'b1;
        acc1_q  <= acc1_nx;
        acc2_q  <= acc2_nx;
      end else begin
        cyc_q  <= cyc_q + {16'h0000, tick};
        acc1_q <= acc1_nx;
        acc2_q <= acc2_nx;
      end
    end
  end

  // Results survive disable so the host can still read the last conversion
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      result_q <= 16'h0000;
      tcap_q   <= 16'h0000;
    end else if (done) begin
      result_q <= res_nx;
      tcap_q   <= timer_q + {15'h0000, tick};
    end
  end

  // Alert flag: a new alert wins over a clear in the same cycle
  logic flag_d, flag_clr;
  assign flag_clr = clear_q |
                    (wr_q & (wr_idx_q == alac_pkg::REG_GAIN) &
                     ~wr_data_q[alac_pkg::GAIN_FLAG_BIT]);
  assign flag_d = alert_set | (flag_q & ~flag_clr);
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      flag_q  <= 1'b0;
      int_n_q <= 1'b1;
    end else begin
      flag_q  <= flag_d;
      int_n_q <= ~flag_d;
    end
  end

  logic sda_lo_q;
  always_ff @(posedge clk_in) begin
    sda_lo_q <= 1'b0;
  end
  assign sda_out    = sda_lo_q;
  assign sda_oe_out = oe_q;
  assign int_n_out  = int_n_q;
endmodule // alac_ctrl

// [alac_ctrl_sva.sv]
// Port assertions for the light-sensor control block
`timescale 1ns/1ps
module alac_ctrl_sva (
  // Clock and reset
  input wire logic clk_in,
  input wire logic srst_in,
  // Bus and alert pins
  input wire logic scl_in,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe_out,
  input wire logic int_n_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (srst_in);
  a_reset_quiet: assert property (disable iff (1'b0) srst_in |=> !sda_oe_out && int_n_out)
    else $error("bus or alert active in reset");
  a_alert_idle_start: assert property ($fell(srst_in) |-> int_n_out [*3])
    else $error("alert low right after reset");
  a_drive_low_only: assert property (sda_oe_out |-> !sda_out)
    else $error("data pin driven high");
  a_oe_scl_high: assert property (scl_in && $past(scl_in) |-> $stable(sda_oe_out))
    else $error("data drive changed while clock high");
  a_oe_bit_width: assert property ($rose(sda_oe_out) |-> sda_oe_out [*5])
    else $error("data drive shorter than a bit");
  a_start_releases: assert property (scl_in && $fell(sda_in) |=> !sda_oe_out [*4])
    else $error("data driven after start");
  a_stop_released: assert property (scl_in && $rose(sda_in) |-> !sda_oe_out)
    else $error("data driven at stop");
  a_clear_by_bus: assert property ($rose(int_n_out) |-> !scl_in)
    else $error("alert cleared outside a bus write");
endmodule // alac_ctrl_sva
bind alac_ctrl alac_ctrl_sva u_sva (.clk_in(clk_in), .srst_in(srst_in), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe_out(sda_oe_out), .int_n_out(int_n_out));

// [alac_host.sv]
// Two-wire host model driving the bus for the bench
`timescale 1ns/1ps
module alac_host (
  // Clock and resolved data wire
  input  wire logic       clk_in,
  input  wire logic       sda_wire_in,
  // Lines, high means released to the pull-up
  output logic            scl_out,
  output logic            sda_out,
  // Received byte, valid one cycle
  output logic [7:0]      rd_data_out,
  output logic            rd_valid_out
);
  initial begin
    scl_out = 1'b1;
    sda_out = 1'b1;
    rd_data_out = 8'h00;
    rd_valid_out = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  // Low 6 cycles, high 2; data moves mid-low so no false start or stop
  task automatic bit_io(input logic b, output logic s);
    scl_out <= 1'b0;
    tick(3);
    sda_out <= b;
    tick(3);
    scl_out <= 1'b1;
    tick(2);
    s = sda_wire_in;
  endtask
  // Also a repeated start from the high phase of a bit
  task automatic start_cond();
    scl_out <= 1'b0;
    tick(3);
    sda_out <= 1'b1;
    tick(3);
    scl_out <= 1'b1;
    tick(4);
    sda_out <= 1'b0;
    tick(4);
  endtask
  task automatic stop_cond();
    scl_out <= 1'b0;
    tick(3);
    sda_out <= 1'b0;
    tick(3);
    scl_out <= 1'b1;
    tick(4);
    sda_out <= 1'b1;
    tick(8);
  endtask
  task automatic wr_byte(input logic [7:0] b, output logic nack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(b[i], s);
    bit_io(1'b1, nack);
  endtask
  task automatic rd_byte(input logic nack);
    logic [7:0] r;
    logic       s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, r[i]);
    bit_io(nack, s);
    rd_data_out <= r;
    rd_valid_out <= 1'b1;
    tick(1);
    rd_valid_out <= 1'b0;
  endtask
endmodule // alac_host

// [tb_ambient_light_adc_control.sv]
// Self-checking bench for the light-sensor control block
`timescale 1ns/1ps
module tb_ambient_light_adc_control;
  logic        clk_in = 1'b0;
  logic        srst_in = 1'b1;
  logic        diode1_in = 1'b0;
  logic        diode2_in = 1'b0;
  logic        d1_force = 1'b0;
  logic        scl_line;
  logic        sda_host;
  logic        sda_out;
  logic        sda_oe_out;
  logic        int_n_out;
  logic [7:0]  rd_data;
  logic        rd_valid;
  logic [31:0] lfsr_q = 32'h6ed3;
  logic [7:0]  exp_q[$];
  int          miscompares = 0;
  int          samples_checked = 0;
  wire         sda_line = sda_host & ~sda_oe_out;

  always #5 clk_in = ~clk_in;
  alac_ctrl #(.CYC_W0(32), .CYC_W1(16), .CYC_W2(8), .CYC_W3(4)) dut (
    .clk_in(clk_in), .srst_in(srst_in), .scl_in(scl_line), .sda_in(sda_line),
    .sda_out(sda_out), .sda_oe_out(sda_oe_out), .diode1_in(diode1_in),
    .diode2_in(diode2_in), .int_n_out(int_n_out));
  alac_host host (.clk_in(clk_in), .sda_wire_in(sda_line), .scl_out(scl_line),
    .sda_out(sda_host), .rd_data_out(rd_data), .rd_valid_out(rd_valid));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // Forcing diode one high makes every tick count, so results are known
  always @(posedge clk_in) begin
    lfsr_q <= lfsr(lfsr_q);
    diode1_in <= d1_force | lfsr_q[3];
    diode2_in <= lfsr_q[0];
  end

  task automatic report_and_stop();
    $display("checked %0d mismatched %0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  task automatic check_byte(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected byte at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  task automatic check_bit(input logic got, input logic exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("unexpected bit at %0t: %h vs %h", $time, got, exp);
    end
  endtask
  always @(posedge clk_in) begin
    if (rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check_bit(1'b1, 1'b0);
      else check_byte(rd_data, exp_q.pop_front());
    end
  end

  task automatic send(input logic [7:0] b, input logic nack);
    logic a;
    host.wr_byte(b, a);
    check_bit(a, nack);
  endtask
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    host.start_cond();
    send(8'h88, 1'b0);
    send(p, 1'b0);
    send(d, 1'b0);
    host.stop_cond();
  endtask
  task automatic rd(input logic [7:0] p, input int n);
    host.start_cond();
    send(8'h88, 1'b0);
    send(p, 1'b0);
    host.start_cond();
    send(8'h89, 1'b0);
    for (int i = 0; i < n; i++) host.rd_byte(i == n - 1);
    host.stop_cond();
  endtask
  task automatic wait_int(input logic lvl, input int lim);
    for (int i = 0; i < lim && int_n_out !== lvl; i++) @(posedge clk_in);
    check_bit(int_n_out, lvl);
    if (int_n_out !== lvl) report_and_stop();
  endtask

  initial begin
    #900000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (6) @(posedge clk_in);
    srst_in <= 1'b0;
    repeat (4) @(posedge clk_in);
    exp_q = {8'h00, 8'h00, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
    rd(8'h00, 8);
    host.start_cond();
    send(8'h8a, 1'b1);
    host.stop_cond();
    exp_q = {8'h00};
    rd(8'h08, 1);
    wr(8'h02, 8'h12);
    wr(8'h03, 8'h34);
    exp_q = {8'h12, 8'h34};
    rd(8'h02, 2);
    // Upper limit zero puts any nonzero reading out of window
    d1_force <= 1'b1;
    wr(8'h02, 8'h00);
    wr(8'h01, 8'h0c);
    wr(8'h00, 8'h83);
    wait_int(1'b0, 2000);
    exp_q = {8'h2c, 8'h00, 8'h34, 8'h04, 8'h00};
    rd(8'h01, 5);
    // Open the window on both sides so the reading of four is inside it
    wr(8'h03, 8'h00);
    wr(8'h02, 8'hff);
    repeat (700) @(posedge clk_in);
    wr(8'h01, 8'h0c);
    wait_int(1'b1, 50);
    exp_q = {8'h0c};
    rd(8'h01, 1);
    wr(8'h01, 8'h0f);
    wr(8'h02, 8'h00);
    repeat (14 * 608) @(posedge clk_in);
    check_bit(int_n_out, 1'b1);
    wait_int(1'b0, 4 * 608);
    wr(8'h02, 8'hff);
    repeat (700) @(posedge clk_in);
    host.start_cond();
    send(8'h88, 1'b0);
    send(8'h41, 1'b0);
    host.stop_cond();
    wait_int(1'b1, 50);
    wr(8'h00, 8'h03);
    wr(8'h00, 8'h43);
    exp_q = {8'h43, 8'h0f, 8'hff, 8'h00, 8'h04, 8'h00};
    rd(8'h00, 6);
    // External timing: nothing ends an integration until a restart strobe
    wr(8'h00, 8'ha3);
    wr(8'h01, 8'h0c);
    wr(8'h02, 8'h00);
    repeat (2000) @(posedge clk_in);
    check_bit(int_n_out, 1'b1);
    host.start_cond();
    send(8'h88, 1'b0);
    send(8'h80, 1'b0);
    host.stop_cond();
    wait_int(1'b0, 50);
    check_bit(exp_q.size() == 0, 1'b1);
    report_and_stop();
  end
endmodule // tb_ambient_light_adc_control
